// ==== dv/rsc_pin_model.sv ====
// reset pin model: weak pull-up and board drive
module rsc_pin_model (
    input wire logic aclk, // clock
    input wire logic pull_low, // board drives pin low
    input wire logic oe, // design drive enable
    input wire logic out, // design drive value
    input wire logic pull_on, // weak pull-up on
    output logic pin // pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt = 1'b0;
    always @(posedge aclk) flt <= ~flt;
    // floating pin wanders when nothing pulls it
    assign pin = oe ? out : pull_low ? 1'b0 : pull_on ? 1'b1 : flt;
endmodule : rsc_pin_model

// ==== dv/rsc_reset_ctrl_test.sv ====
// bench for the reset source controller
module rsc_reset_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic wr;
        logic [3:0] a;
        logic [7:0] d;
        logic [1:0] r;
    } rsc_row_s;
    // write flag, address, data, response
    localparam rsc_row_s ROWS [10] = '{15'h0204, 15'h4000, 15'h0004,
        15'h50FC, 15'h10FC, 15'h200C, 15'h7000, 15'h3000, 15'h4803, 15'h0803};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, a_ok, w_ok;
    logic [1:0] bresp, rresp, r;
    rsc_pkg::rsc_cfg_s cfg = 6'h3C;
    logic [6:0] evt = 7'h00;
    logic por_low = 1'b0, below = 1'b0, uv_rdy = 1'b1, pull_low = 1'b0;
    logic pin, p_out, p_oe, p_up, gpio, uv_en, exec_en, rst_n;
    int mismatches = 0, checks = 0;
    rsc_reset_ctrl #(.POWER_UP_CYCLES(20)) dut_u (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cfg(cfg), .evt(evt), .por_low(por_low),
        .vdd_below_threshold(below), .undervolt_circuit_ready(uv_rdy),
        .ext_reset_pin_in(pin), .ext_reset_pin_out(p_out),
        .ext_reset_pin_oe(p_oe), .ext_reset_pin_pullup(p_up),
        .ext_reset_pin_gpio(gpio), .undervolt_circuit_en(uv_en),
        .cpu_exec_en(exec_en), .dev_reset_n(rst_n));
    rsc_pin_model pin_u (.aclk(aclk), .pull_low(pull_low), .oe(p_oe),
        .out(p_out), .pull_on(p_up), .pin(pin));
    initial forever #12.5 aclk = ~aclk;
    task automatic cmp(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            a_ok = awvalid & awready;
            w_ok = wvalid & wready;
            @(posedge aclk);
            if (a_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end while ((awvalid & ~a_ok) | (wvalid & ~w_ok));
        bready <= 1'b1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
    endtask : rd
    task automatic go();
        repeat (200) if (rst_n !== 1'b1) @(posedge aclk);
        cmp("released", 1'b1, rst_n);
    endtask : go
    task automatic ev(input logic [6:0] e, input logic rst, logic [7:0] f);
        evt <= e;
        @(posedge aclk);
        evt <= 7'h00;
        repeat (3) @(posedge aclk);
        cmp("dev_reset_n", !rst, rst_n);
        go();
        rd(4'h4);
        cmp("flags", {24'h0, f}, d);
    endtask : ev
    task automatic hit(input logic pn, input int n, input logic rst);
        if (pn) pull_low <= 1'b1;
        else below <= 1'b1;
        repeat (n) @(posedge aclk);
        pull_low <= 1'b0;
        below <= 1'b0;
        repeat (12) @(posedge aclk);
        cmp("dev_reset_n", !rst, rst_n);
        cmp("pin_oe", 1'b0, p_oe);
        cmp("pin_out", 1'b0, p_out);
        go();
    endtask : hit
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (15) @(posedge aclk);
        cmp("timer hold", 1'b0, rst_n);
        go();
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) wr(ROWS[i].a, {24'h0, ROWS[i].d});
            else rd(ROWS[i].a);
            if (!ROWS[i].wr) cmp("rdata", {24'h0, ROWS[i].d}, d);
            cmp("resp", ROWS[i].r, r);
        end
        ev(7'h08, 1'b0, 8'hBF);
        cfg.stack_reset_enable <= 1'b1;
        ev(7'h04, 1'b1, 8'hFF);
        ev(7'h10, 1'b1, 8'hFB);
        ev(7'h40, 1'b1, 8'hEB);
        rd(4'h8);
        cmp("status", 32'h1, d);
        ev(7'h20, 1'b1, 8'hCB);
        hit(1'b1, 4, 1'b0);
        hit(1'b1, 6, 1'b1);
        {cfg.ext_reset_pin_enable, cfg.low_voltage_prog_enable} <= 2'b01;
        hit(1'b1, 6, 1'b1);
        cfg.low_voltage_prog_enable <= 1'b0;
        hit(1'b1, 6, 1'b0);
        pull_low <= 1'b1;
        repeat (2) @(posedge aclk);
        cmp("gpio", 1'b0, gpio);
        cmp("pullup", 1'b0, p_up);
        pull_low <= 1'b0;
        wr(4'hC, 32'h1);
        cmp("pullup", 1'b1, p_up);
        cmp("gpio", 1'b1, gpio);
        cfg.ext_reset_pin_enable <= 1'b1;
        hit(1'b0, 6, 1'b0);
        hit(1'b0, 12, 1'b1);
        rd(4'h4);
        cmp("flags", 32'hC2, d);
        cfg.bor_mode_select <= rsc_pkg::BOR_ALWAYS_OFF;
        hit(1'b0, 12, 1'b0);
        cmp("uv_en", 1'b0, uv_en);
        cfg.bor_mode_select <= rsc_pkg::BOR_SOFTWARE;
        hit(1'b0, 12, 1'b0);
        wr(4'h0, 32'h80);
        hit(1'b0, 12, 1'b1);
        cmp("uv_en", 1'b1, uv_en);
        cfg.bor_mode_select <= rsc_pkg::BOR_SLEEP_OFF;
        evt <= 7'h01;
        hit(1'b0, 12, 1'b0);
        cmp("uv_en", 1'b0, uv_en);
        evt <= 7'h00;
        uv_rdy <= 1'b0;
        repeat (2) @(posedge aclk);
        cmp("exec_en", 1'b0, exec_en);
        uv_rdy <= 1'b1;
        por_low <= 1'b1;
        @(negedge aclk);
        cmp("por hold", 1'b0, rst_n);
        @(posedge aclk);
        por_low <= 1'b0;
        repeat (15) @(posedge aclk);
        cmp("por timer", 1'b0, rst_n);
        go();
        evt <= 7'h02;
        @(posedge aclk);
        evt <= 7'h00;
        repeat (15) @(posedge aclk);
        cmp("prog exit", 1'b0, rst_n);
        go();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        complete_run();
    end
endmodule : rsc_reset_ctrl_test

// ==== verilog/rsc_pkg.sv ====
// package of constants and carriers for the reset source controller
package rsc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_UNDERVOLT_CTRL = 4'h0;
    localparam logic [3:0] ADDR_POWER_CTRL = 4'h4;
    localparam logic [3:0] ADDR_CORE_STATUS = 4'h8;
    localparam logic [3:0] ADDR_PIN_CTRL = 4'hC;

    localparam int SW_UNDERVOLT_EN_BIT = 7;
    localparam int UNDERVOLT_READY_BIT = 0;
    localparam int STK_OVF_BIT = 7;
    localparam int STK_UNF_BIT = 6;
    localparam int WIN_VIOL_BIT = 5;
    localparam int WDT_RST_BIT = 4;
    localparam int EXT_RST_BIT = 3;
    localparam int RST_INSTR_BIT = 2;
    localparam int POR_BIT = 1;
    localparam int BOR_BIT = 0;
    localparam int TIMEOUT_BIT = 1;
    localparam int POWERDOWN_BIT = 0;
    localparam int PULLUP_BIT = 0;

    localparam logic SW_UNDERVOLT_EN_RST = 1'b1;
    localparam logic [7:0] POWER_CTRL_RST = 8'h3C;
    localparam logic [1:0] CORE_STATUS_RST = 2'h3;
    localparam logic PULLUP_RST = 1'b1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // brown-out modes
    // ------------------------------------------------------------
    localparam logic [1:0] BOR_ALWAYS_ON = 2'h3;
    localparam logic [1:0] BOR_SLEEP_OFF = 2'h2;
    localparam logic [1:0] BOR_SOFTWARE = 2'h1;
    localparam logic [1:0] BOR_ALWAYS_OFF = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 40000;
    localparam int POWER_UP_TIMER_MS = 64;
    localparam int POWER_UP_CYCLES = POWER_UP_TIMER_MS * CLK_KHZ;
    localparam int EXEC_DELAY_FOSC = 10;
    localparam int UNDERVOLT_FILTER_CYCLES = 8;
    localparam int EXT_PIN_FILTER_CYCLES = 4;
    localparam int TIMER_W = 22;
    localparam int FILT_W = 8;
    localparam int DLY_W = 4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] bor_mode_select;
        logic power_up_timer_en;
        logic ext_reset_pin_enable;
        logic low_voltage_prog_enable;
        logic stack_reset_enable;
    } rsc_cfg_s;

    typedef struct packed {
        logic watchdog_overflow;
        logic window_violation;
        logic reset_instr;
        logic stack_overflow;
        logic stack_underflow;
        logic prog_mode_exit;
        logic sleeping;
    } rsc_evt_s;

    typedef enum logic [4:0] {
        ST_HOLD = 5'h01,
        ST_POWER_UP_TIMER = 5'h02,
        ST_BORWAIT = 5'h04,
        ST_DELAY = 5'h08,
        ST_RUN = 5'h10
    } rsc_state_e;

endpackage : rsc_pkg

// ==== verilog/rsc_reset_ctrl.sv ====
// reset source controller: source merge, timers, flags, axi4-lite regs
// Contract
// - eight sources each produce device reset
// - hold reset while power-on detector low
// - optional power-up timer stretches power resets
// - two-bit field selects four brown-out modes
// - brown-out trips only after filter duration
// - always-on: start waits ready, sleep protected
// - sleep-off: no protection asleep, wake waits
// - software mode: enable bit gates protection
// - always-off: never resets, never delays start
// - software enable bit 7 always read/write
// - bit 0 ready flag, bits 6-1 zero
// - pin reset enabled by lvp or enable
// - enabled pin low holds device in reset
// - pin path filters out short pulses
// - never drive reset pin low
// - disabled pin is gpio, software pull-up
// - watchdog expiry resets the device
// - overflow and window violation set distinct flags
// - reset instruction resets, clears its flag
// - stack resets only with enable, flag records
// - power-up timer holds reset 64 ms
// - start 10 cycles after pin release
// - only actual cause flag is updated; on power-on reset the code loads bits 7-1 from POWER_CTRL_RST
// - programming exit behaves as power-on reset
//
// Added by the designer: the address map and the AXI4-Lite register port.
module rsc_reset_ctrl #(
    parameter int unsigned POWER_UP_CYCLES = rsc_pkg::POWER_UP_CYCLES
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire rsc_pkg::rsc_cfg_s cfg, // configuration fuses
    input wire rsc_pkg::rsc_evt_s evt, // core event pulses
    input wire logic por_low, // power-on detector, supply low
    input wire logic vdd_below_threshold, // undervolt comparator
    input wire logic undervolt_circuit_ready, // brown-out circuit ready
    input wire logic ext_reset_pin_in, // reset pin level
    output logic ext_reset_pin_out, // reset pin drive value
    output logic ext_reset_pin_oe, // reset pin drive enable
    output logic ext_reset_pin_pullup, // weak pull-up enable
    output logic ext_reset_pin_gpio, // pin as gpio input
    output logic undervolt_circuit_en, // brown-out circuit enable
    output logic cpu_exec_en, // core may execute
    output logic dev_reset_n // device reset, active low
);

    // ------------------------------------------------------------
    // brown-out mode decode
    // ------------------------------------------------------------
    logic sw_undervolt_enable;
    logic [7:0] power_control_reg;
    logic [1:0] core_status;
    logic pin_pullup_sw;
    wire mode_on = cfg.bor_mode_select == rsc_pkg::BOR_ALWAYS_ON;
    wire mode_sleep_off = cfg.bor_mode_select == rsc_pkg::BOR_SLEEP_OFF;
    wire mode_sw = cfg.bor_mode_select == rsc_pkg::BOR_SOFTWARE;
    wire bor_enabled = mode_on | (mode_sleep_off & ~evt.sleeping) |
        (mode_sw & sw_undervolt_enable);
    wire bor_active = bor_enabled & undervolt_circuit_ready;
    wire start_waits = mode_on | mode_sleep_off;
    wire bor_good = undervolt_circuit_ready & ~vdd_below_threshold;

    // ------------------------------------------------------------
    // filters: 0 = undervolt, 1 = external pin
    // ------------------------------------------------------------
    logic [1:0] filt_raw;
    logic [1:0] filt_hit;
    wire pin_enabled = cfg.low_voltage_prog_enable |
        cfg.ext_reset_pin_enable;
    assign filt_raw[0] = bor_active & vdd_below_threshold;
    assign filt_raw[1] = pin_enabled & ~ext_reset_pin_in;

    localparam logic [rsc_pkg::FILT_W-1:0] FILT_LIM [2] = '{
        rsc_pkg::FILT_W'(rsc_pkg::UNDERVOLT_FILTER_CYCLES),
        rsc_pkg::FILT_W'(rsc_pkg::EXT_PIN_FILTER_CYCLES)};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            logic [rsc_pkg::FILT_W-1:0] cnt;
            always_ff @(posedge aclk) begin
                if (!aresetn || !filt_raw[gi]) begin
                    cnt <= '0;
                end else if (cnt != FILT_LIM[gi]) begin
                    cnt <= cnt + 1'b1;
                end
            end
            assign filt_hit[gi] = filt_raw[gi] && cnt == FILT_LIM[gi];
        end
    endgenerate

    wire bor_trip = filt_hit[0];
    wire pin_hold = filt_hit[1];

    // ------------------------------------------------------------
    // source merge
    // ------------------------------------------------------------
    wire ev_por = por_low | evt.prog_mode_exit;
    wire ev_stk = cfg.stack_reset_enable &
        (evt.stack_overflow | evt.stack_underflow);
    wire ev_pulse = evt.watchdog_overflow | evt.window_violation |
        evt.reset_instr | ev_stk;
    wire any_src = ev_por | bor_trip | pin_hold | ev_pulse;

    // ------------------------------------------------------------
    // release sequencer
    // ------------------------------------------------------------
    rsc_pkg::rsc_state_e state;
    rsc_pkg::rsc_state_e next_state;
    logic power_evt;
    logic [rsc_pkg::TIMER_W-1:0] timer;
    localparam logic [rsc_pkg::TIMER_W-1:0] POWER_UP_TIMER_LAST =
        rsc_pkg::TIMER_W'(POWER_UP_CYCLES - 1);
    localparam logic [rsc_pkg::TIMER_W-1:0] DELAY_LAST =
        rsc_pkg::TIMER_W'(rsc_pkg::EXEC_DELAY_FOSC - 1);
    wire timer_done_power_up_timer = timer == POWER_UP_TIMER_LAST;
    wire timer_done_dly = timer == DELAY_LAST;

    always_comb begin
        next_state = state;
        unique case (state)
            rsc_pkg::ST_HOLD: begin
                if (!any_src) begin
                    next_state = (power_evt && cfg.power_up_timer_en) ?
                        rsc_pkg::ST_POWER_UP_TIMER : rsc_pkg::ST_BORWAIT;
                end
            end
            rsc_pkg::ST_POWER_UP_TIMER: begin
                if (any_src) begin
                    next_state = rsc_pkg::ST_HOLD;
                end else if (timer_done_power_up_timer) begin
                    next_state = rsc_pkg::ST_BORWAIT;
                end
            end
            rsc_pkg::ST_BORWAIT: begin
                if (any_src) begin
                    next_state = rsc_pkg::ST_HOLD;
                end else if (!start_waits || bor_good) begin
                    next_state = rsc_pkg::ST_DELAY;
                end
            end
            rsc_pkg::ST_DELAY: begin
                if (any_src) begin
                    next_state = rsc_pkg::ST_HOLD;
                end else if (timer_done_dly) begin
                    next_state = rsc_pkg::ST_RUN;
                end
            end
            rsc_pkg::ST_RUN: begin
                if (any_src) begin
                    next_state = rsc_pkg::ST_HOLD;
                end
            end
            default: next_state = rsc_pkg::ST_HOLD;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= rsc_pkg::ST_HOLD;
            power_evt <= 1'b1;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= (next_state != state) ? '0 : timer + 1'b1;
            if (ev_por || bor_trip) begin
                power_evt <= 1'b1;
            end else if (state == rsc_pkg::ST_BORWAIT) begin
                power_evt <= 1'b0;
            end
        end
    end

    // async assert, two-flop release
    wire hold_async = por_low | (state != rsc_pkg::ST_RUN);
    logic [1:0] rel_sync;
    always_ff @(posedge aclk or posedge hold_async) begin
        if (hold_async) begin
            rel_sync <= 2'h0;
        end else begin
            rel_sync <= {rel_sync[0], 1'b1};
        end
    end
    assign dev_reset_n = rel_sync[1];
    // wake from sleep waits for the circuit in sleep-off mode
    assign cpu_exec_en = dev_reset_n & ~evt.sleeping &
        ~(mode_sleep_off & ~undervolt_circuit_ready);

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign ext_reset_pin_out = 1'b0;
    assign ext_reset_pin_oe = 1'b0;
    assign ext_reset_pin_pullup = pin_enabled | pin_pullup_sw;
    assign ext_reset_pin_gpio = ~pin_enabled & ext_reset_pin_in;
    assign undervolt_circuit_en = bor_enabled;

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic aw_full;
    logic w_full;
    logic [3:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full & ~s_axi_bvalid;
    wire do_write = aw_full & w_full & ~s_axi_bvalid;
    wire wr_uv = do_write & w_lane & aw_addr == rsc_pkg::ADDR_UNDERVOLT_CTRL;
    wire wr_pc = do_write & w_lane & aw_addr == rsc_pkg::ADDR_POWER_CTRL;
    wire wr_pin = do_write & w_lane & aw_addr == rsc_pkg::ADDR_PIN_CTRL;
    wire wr_hit = aw_addr == rsc_pkg::ADDR_UNDERVOLT_CTRL ||
        aw_addr == rsc_pkg::ADDR_POWER_CTRL ||
        aw_addr == rsc_pkg::ADDR_CORE_STATUS ||
        aw_addr == rsc_pkg::ADDR_PIN_CTRL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_byte <= '0;
            w_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rsc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? rsc_pkg::RESP_OKAY :
                    rsc_pkg::RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire [7:0] uv_read = {sw_undervolt_enable, 6'h00,
        undervolt_circuit_ready};
    wire [31:0] rd_mux =
        (s_axi_araddr == rsc_pkg::ADDR_UNDERVOLT_CTRL) ? {24'h0, uv_read} :
        (s_axi_araddr == rsc_pkg::ADDR_POWER_CTRL) ?
            {24'h0, power_control_reg} :
        (s_axi_araddr == rsc_pkg::ADDR_CORE_STATUS) ? {30'h0, core_status} :
        (s_axi_araddr == rsc_pkg::ADDR_PIN_CTRL) ? {31'h0, pin_pullup_sw} :
        32'h0;
    wire rd_hit = s_axi_araddr == rsc_pkg::ADDR_UNDERVOLT_CTRL ||
        s_axi_araddr == rsc_pkg::ADDR_POWER_CTRL ||
        s_axi_araddr == rsc_pkg::ADDR_CORE_STATUS ||
        s_axi_araddr == rsc_pkg::ADDR_PIN_CTRL;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= rsc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control and cause flags, hardware wins over software
    // ------------------------------------------------------------
    logic [7:0] next_pc;
    logic [1:0] next_status;
    always_comb begin
        next_pc = wr_pc ? w_byte : power_control_reg;
        next_status = core_status;
        if (ev_por) begin
            next_pc = rsc_pkg::POWER_CTRL_RST;
            next_pc[rsc_pkg::BOR_BIT] = power_control_reg[rsc_pkg::BOR_BIT];
            next_status = rsc_pkg::CORE_STATUS_RST;
        end else begin
            if (bor_trip) begin
                next_pc[rsc_pkg::BOR_BIT] = 1'b0;
                next_status = rsc_pkg::CORE_STATUS_RST;
            end
            if (pin_hold) begin
                next_pc[rsc_pkg::EXT_RST_BIT] = 1'b0;
            end
            if (evt.watchdog_overflow) begin
                next_pc[rsc_pkg::WDT_RST_BIT] = 1'b0;
                next_status[rsc_pkg::TIMEOUT_BIT] = 1'b0;
            end
            if (evt.window_violation) begin
                next_pc[rsc_pkg::WIN_VIOL_BIT] = 1'b0;
            end
            if (evt.reset_instr) begin
                next_pc[rsc_pkg::RST_INSTR_BIT] = 1'b0;
            end
            if (evt.stack_overflow) begin
                next_pc[rsc_pkg::STK_OVF_BIT] = 1'b1;
            end
            if (evt.stack_underflow) begin
                next_pc[rsc_pkg::STK_UNF_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_control_reg <= rsc_pkg::POWER_CTRL_RST;
            core_status <= rsc_pkg::CORE_STATUS_RST;
            sw_undervolt_enable <= rsc_pkg::SW_UNDERVOLT_EN_RST;
            pin_pullup_sw <= rsc_pkg::PULLUP_RST;
        end else begin
            power_control_reg <= next_pc;
            core_status <= next_status;
            if (wr_uv) begin
                sw_undervolt_enable <= w_byte[rsc_pkg::SW_UNDERVOLT_EN_BIT];
            end
            if (wr_pin) begin
                pin_pullup_sw <= w_byte[rsc_pkg::PULLUP_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_released;
        state == rsc_pkg::ST_RUN [*3];
    endsequence

    sequence s_delay_held;
        (state == rsc_pkg::ST_DELAY || any_src) [*8] ##1
            (state == rsc_pkg::ST_DELAY || any_src) [*2];
    endsequence

    property p_por_hold;
        @(posedge aclk) disable iff (!aresetn) por_low |-> ##[0:1] !dev_reset_n;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("por not held");

    property p_release;
        @(posedge aclk) disable iff (!aresetn)
        s_released |-> dev_reset_n || $past(por_low) || por_low;
    endproperty
    a_release: assert property (p_release) else $error("late release");

    property p_power_up_timer;
        @(posedge aclk) disable iff (!aresetn)
        $fell(state == rsc_pkg::ST_POWER_UP_TIMER) && state == rsc_pkg::ST_BORWAIT |->
            $past(timer) == POWER_UP_TIMER_LAST;
    endproperty
    a_power_up_timer: assert property (p_power_up_timer) else $error("power_up_timer too short");

    property p_delay;
        @(posedge aclk) disable iff (!aresetn)
        $rose(state == rsc_pkg::ST_DELAY) |-> s_delay_held;
    endproperty
    a_delay: assert property (p_delay) else $error("exec delay wrong");

    property p_off_mode;
        @(posedge aclk) disable iff (!aresetn)
        cfg.bor_mode_select == rsc_pkg::BOR_ALWAYS_OFF |-> !filt_raw[0];
    endproperty
    a_off_mode: assert property (p_off_mode) else $error("bor in off");

    property p_pin_never_driven;
        @(posedge aclk) disable iff (!aresetn) !ext_reset_pin_oe;
    endproperty
    a_pin_never_driven: assert property (p_pin_never_driven)
        else $error("pin driven");

    property p_pin_filter;
        @(posedge aclk) disable iff (!aresetn)
        $rose(filt_raw[1]) |-> !pin_hold [*4];
    endproperty
    a_pin_filter: assert property (p_pin_filter) else $error("no filter");

    property p_pin_reset;
        @(posedge aclk) disable iff (!aresetn)
        pin_enabled && !ext_reset_pin_in [*6] |=> state == rsc_pkg::ST_HOLD;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin ignored");

    property p_ri_flag;
        @(posedge aclk) disable iff (!aresetn)
        evt.reset_instr && !ev_por |=>
            !power_control_reg[rsc_pkg::RST_INSTR_BIT] &&
            state == rsc_pkg::ST_HOLD;
    endproperty
    a_ri_flag: assert property (p_ri_flag) else $error("ri flag");

    property p_stack_gate;
        @(posedge aclk) disable iff (!aresetn)
        state == rsc_pkg::ST_RUN && !cfg.stack_reset_enable &&
        evt.stack_overflow && !ev_por && !bor_trip && !pin_hold &&
        !evt.watchdog_overflow && !evt.window_violation &&
        !evt.reset_instr |=> state == rsc_pkg::ST_RUN;
    endproperty
    a_stack_gate: assert property (p_stack_gate) else $error("stk reset");

    property p_wdt_flags;
        @(posedge aclk) disable iff (!aresetn)
        evt.window_violation && !evt.watchdog_overflow && !ev_por &&
        !bor_trip |=> core_status[rsc_pkg::TIMEOUT_BIT] ==
            $past(core_status[rsc_pkg::TIMEOUT_BIT]);
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("wv flag");

endmodule : rsc_reset_ctrl
